// file: rtl/tce_capture.sv
/*
 * Capture-input and edge-detection logic of a 16-bit timer/event counter.
 * Assumes a prescaler in the clk_sys domain that supplies one-cycle rise and
 * fall ticks of the count clock, and a counter that supplies its current value.
 */
`timescale 1ns/10ps

module tce_capture #(
    parameter int CNT_W = tce_pkg::CNT_W
) (
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic                   clk_en,
    input  wire logic                   timer_run,
    input  wire logic                   count_rise_tick,
    input  wire logic                   count_fall_tick,
    input  wire logic                   trig_a_is_count_clk,
    input  wire tce_pkg::tce_edge_cfg_t prescaler_mode_reg,
    input  wire tce_pkg::tce_ctrl_t     capture_compare_ctrl,
    input  wire logic [CNT_W-1:0]       timer_count_value,
    input  wire logic                   trigger_in_a,
    input  wire logic                   trigger_in_b,
    output logic                        count_edge_a,
    output logic [CNT_W-1:0]            capture_reg_a,
    output logic [CNT_W-1:0]            capture_reg_b,
    output tce_pkg::tce_irq_t           capture_irq
);

    // Capture registers and reset values are sized for the 16-bit counter
    if (CNT_W != tce_pkg::CNT_W) begin : g_bad_width
        $error("tce_capture: counter width must be 16");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers, three stages per pin
    // ------------------------------------------------------------------
    logic [1:0] s1_q, s2_q, s3_q;
    logic [1:0] pin_q, pin_d;

    always_comb begin
        pin_d = pin_q;
        for (int i = 0; i < 2; i++) begin
            // Only the second and third stages are compared
            if (s2_q[i] == s3_q[i]) begin
                pin_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s1_q  <= 2'h0;
            s2_q  <= 2'h0;
            s3_q  <= 2'h0;
            pin_q <= 2'h0;
        end else if (clk_en) begin
            s1_q  <= {trigger_in_b, trigger_in_a};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= pin_d;
        end
    end

    // ------------------------------------------------------------------
    // Noise filter and edge detection
    // ------------------------------------------------------------------
    logic [1:0] filt_q, filt_d;
    logic [1:0] cand_q, cand_d;
    logic       ran_q, ran_d;
    logic [1:0] rise_ev, fall_ev, valid_ev, opp_ev;
    logic [1:0] tick;
    logic [1:0] sel [2];

    always_comb begin
        filt_d   = filt_q;
        cand_d   = cand_q;
        ran_d    = ran_q | timer_run;
        rise_ev  = 2'h0;
        fall_ev  = 2'h0;
        valid_ev = 2'h0;
        opp_ev   = 2'h0;
        sel[0]   = prescaler_mode_reg.edge_a;
        sel[1]   = prescaler_mode_reg.edge_b;
        tick[0]  = trig_a_is_count_clk ? 1'b1 : count_rise_tick;
        tick[1]  = count_rise_tick;
        for (int i = 0; i < 2; i++) begin
            if (!timer_run) begin
                cand_d[i] = 1'b0;
                // Before the first run the filter stays low, so a pin already
                // high is seen as rising on the first enable
                if (ran_q) begin
                    filt_d[i] = pin_q[i];
                end
            end else if (tick[i]) begin
                if (pin_q[i] != filt_q[i]) begin
                    cand_d[i] = 1'b1;
                    if (cand_q[i]) begin
                        filt_d[i] = pin_q[i];
                        cand_d[i] = 1'b0;
                        rise_ev[i] = pin_q[i];
                        fall_ev[i] = !pin_q[i];
                    end
                end else begin
                    cand_d[i] = 1'b0;
                end
            end
            unique case (sel[i])
                tce_pkg::EDGE_FALL: begin
                    valid_ev[i] = fall_ev[i];
                    opp_ev[i]   = rise_ev[i];
                end
                tce_pkg::EDGE_RISE: begin
                    valid_ev[i] = rise_ev[i];
                    opp_ev[i]   = fall_ev[i];
                end
                tce_pkg::EDGE_BOTH: begin
                    valid_ev[i] = rise_ev[i] | fall_ev[i];
                    opp_ev[i]   = rise_ev[i] | fall_ev[i];
                end
                default: begin
                    // Prohibited code detects nothing
                    valid_ev[i] = 1'b0;
                    opp_ev[i]   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            filt_q <= 2'h0;
            cand_q <= 2'h0;
            ran_q  <= 1'b0;
        end else if (clk_en) begin
            filt_q <= filt_d;
            cand_q <= cand_d;
            ran_q  <= ran_d;
        end
    end

    // ------------------------------------------------------------------
    // Capture and interrupt timing
    // ------------------------------------------------------------------
    logic             cap_pend_a_q, cap_pend_a_d;
    logic             cap_pend_b_q, cap_pend_b_d;
    logic             irq_a_en_q, irq_a_en_d;
    logic             irq_pend_a_q, irq_pend_a_d;
    logic             irq_pend_b_q, irq_pend_b_d;
    logic [CNT_W-1:0] cap_a_q, cap_a_d, cap_b_q, cap_b_d;
    logic             cnt_edge_q, cnt_edge_d;
    tce_pkg::tce_irq_t irq_q, irq_d;
    logic             rev, trig_a_cap, trig_b_cap;

    always_comb begin
        rev          = capture_compare_ctrl.reverse_phase_capture_sel;
        cap_pend_a_d = cap_pend_a_q;
        cap_pend_b_d = cap_pend_b_q;
        irq_a_en_d   = irq_a_en_q;
        irq_pend_a_d = irq_pend_a_q;
        irq_pend_b_d = irq_pend_b_q;
        cap_a_d      = cap_a_q;
        cap_b_d      = cap_b_q;
        irq_d        = '0;
        cnt_edge_d   = timer_run && trig_a_is_count_clk && valid_ev[0];
        // Pin A used as count clock gives no capture from pin A
        trig_a_cap   = capture_compare_ctrl.cap_en_a && !trig_a_is_count_clk
                       && (rev ? opp_ev[0] : valid_ev[0]);
        trig_b_cap   = capture_compare_ctrl.cap_en_b && valid_ev[1];

        // Interrupts go out on the count clock rise after the capture, or after the pin B event in reverse phase
        if (count_rise_tick) begin
            irq_d.irq_a  = irq_pend_a_q;
            irq_d.irq_b  = irq_pend_b_q;
            irq_pend_a_d = 1'b0;
            irq_pend_b_d = 1'b0;
        end
        if (count_fall_tick && cap_pend_a_q) begin
            cap_a_d      = timer_count_value;
            cap_pend_a_d = 1'b0;
            irq_pend_a_d = irq_pend_a_d | irq_a_en_q;
        end
        if (count_fall_tick && cap_pend_b_q) begin
            cap_b_d      = timer_count_value;
            cap_pend_b_d = 1'b0;
            irq_pend_b_d = 1'b1;
        end
        // New events are set after the clears so that none is lost
        if (trig_a_cap) begin
            cap_pend_a_d = 1'b1;
            irq_a_en_d   = !rev;
        end
        if (trig_b_cap) begin
            if (rev) begin
                irq_pend_a_d = 1'b1;
            end else begin
                cap_pend_b_d = 1'b1;
            end
        end
        if (!timer_run) begin
            cap_pend_a_d = 1'b0;
            cap_pend_b_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cap_pend_a_q <= 1'b0;
            cap_pend_b_q <= 1'b0;
            irq_a_en_q   <= 1'b0;
            irq_pend_a_q <= 1'b0;
            irq_pend_b_q <= 1'b0;
            cap_a_q      <= tce_pkg::CAP_RST_VAL;
            cap_b_q      <= tce_pkg::CAP_RST_VAL;
            irq_q        <= '0;
            cnt_edge_q   <= 1'b0;
        end else if (clk_en) begin
            cap_pend_a_q <= cap_pend_a_d;
            cap_pend_b_q <= cap_pend_b_d;
            irq_a_en_q   <= irq_a_en_d;
            irq_pend_a_q <= irq_pend_a_d;
            irq_pend_b_q <= irq_pend_b_d;
            cap_a_q      <= cap_a_d;
            cap_b_q      <= cap_b_d;
            irq_q        <= irq_d;
            cnt_edge_q   <= cnt_edge_d;
        end
    end

    assign capture_reg_a = cap_a_q;
    assign capture_reg_b = cap_b_q;
    assign capture_irq   = irq_q;
    assign count_edge_a  = cnt_edge_q;

endmodule : tce_capture

// file: rtl/tce_pkg.sv
/*
 * Package for the capture-input and edge-detection block of the 16-bit timer.
 * It holds the edge-select codes, the capture control layout, widths and reset values.
 * It assumes nothing of its surroundings.
 */
package tce_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          CNT_W       = 16;
    localparam logic [15:0] CAP_RST_VAL = 16'h0000;
    localparam int          SYNC_STAGES = 3;

    // ------------------------------------------------------------------
    // Edge-select field codes, one field per trigger pin
    // ------------------------------------------------------------------
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BAD  = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ------------------------------------------------------------------
    // Capture control bit positions (reverse-phase select is bit 1)
    // ------------------------------------------------------------------
    localparam int CTRL_CAP_EN_A_POS = 0;
    localparam int CTRL_REV_PH_POS   = 1;
    localparam int CTRL_CAP_EN_B_POS = 2;

    typedef struct packed {
        logic cap_en_b;
        logic reverse_phase_capture_sel;
        logic cap_en_a;
    } tce_ctrl_t;

    typedef struct packed {
        logic [1:0] edge_b;
        logic [1:0] edge_a;
    } tce_edge_cfg_t;

    typedef struct packed {
        logic irq_b;
        logic irq_a;
    } tce_irq_t;

endpackage : tce_pkg

// file: verification/tce_capture_chk.sv
/* Port assertions for the capture block.
   Assumes count ticks are one cycle wide and never in the same cycle. */
`timescale 1ns/10ps
module tce_capture_chk #(
    parameter int CNT_W = 16
) (
    input wire logic                   clk_sys,
    input wire logic                   resetn,
    input wire logic                   clk_en,
    input wire logic                   timer_run,
    input wire logic                   count_rise_tick,
    input wire logic                   count_fall_tick,
    input wire logic                   trig_a_is_count_clk,
    input wire tce_pkg::tce_edge_cfg_t prescaler_mode_reg,
    input wire tce_pkg::tce_ctrl_t     capture_compare_ctrl,
    input wire logic [CNT_W-1:0]       timer_count_value,
    input wire logic                   trigger_in_a,
    input wire logic                   trigger_in_b,
    input wire logic                   count_edge_a,
    input wire logic [CNT_W-1:0]       capture_reg_a,
    input wire logic [CNT_W-1:0]       capture_reg_b,
    input wire tce_pkg::tce_irq_t      capture_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence bad_b_s;
        (prescaler_mode_reg.edge_b == tce_pkg::EDGE_BAD) [*8];
    endsequence
    sequence quiet_a_s;
        !capture_irq.irq_a [*2];
    endsequence
    cap_a_a: assert property ($changed(capture_reg_a) |->
        $past(count_fall_tick) && capture_reg_a == $past(timer_count_value)) else $error("capture a");
    cap_b_a: assert property ($changed(capture_reg_b) |->
        $past(count_fall_tick) && capture_reg_b == $past(timer_count_value)) else $error("capture b");
    irq_tick_a: assert property (|capture_irq |-> $past(count_rise_tick)) else $error("irq off tick");
    rev_quiet_a: assert property ($changed(capture_reg_a) &&
        capture_compare_ctrl.reverse_phase_capture_sel |=> quiet_a_s) else $error("reverse irq a");
    rev_b_a: assert property (capture_irq.irq_b |->
        !$past(capture_compare_ctrl.reverse_phase_capture_sel)) else $error("reverse irq b");
    run_stop_a: assert property (count_edge_a |-> $past(timer_run)) else $error("edge while stopped");
    clk_mode_a: assert property (count_edge_a |-> $past(trig_a_is_count_clk)) else $error("edge mode");
    bad_code_a: assert property (bad_b_s |-> !capture_irq.irq_b) else $error("bad code irq");
endmodule : tce_capture_chk
bind tce_capture tce_capture_chk #(.CNT_W(CNT_W)) chk_u (.*);

// file: verification/tce_capture_test.sv
/* Self-checking bench for the capture block.
   Assumes the source model and the checker are compiled alongside. */
`timescale 1ns/10ps
module tce_capture_test;
    logic                   clk_sys = 1'b0;
    logic                   resetn = 1'b0;
    logic                   clk_en = 1'b1;
    logic                   timer_run = 1'b0;
    logic                   trig_a_is_count_clk = 1'b0;
    logic                   count_rise_tick = 1'b0;
    logic                   count_fall_tick = 1'b0;
    logic [15:0]            timer_count_value = 16'h0000;
    tce_pkg::tce_edge_cfg_t prescaler_mode_reg = '0;
    tce_pkg::tce_ctrl_t     capture_compare_ctrl = '0;
    logic                   trigger_in_a, trigger_in_b, count_edge_a;
    logic [15:0]            capture_reg_a, capture_reg_b, t0;
    logic [15:0]            fall_val = 16'h0000, last_a = 16'h0000, last_b = 16'h0000;
    tce_pkg::tce_irq_t      capture_irq;
    int                     err_total = 0, compares = 0, n_a = 0, n_b = 0, n_e = 0, cyc = 0;
    tce_capture dut_u (.*);
    tce_src src_u (.*);
    initial forever #12.5 clk_sys = ~clk_sys;
    // Count clock at half the system rate keeps every tick pair apart
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        count_rise_tick <= cyc[0];
        count_fall_tick <= !cyc[0];
        if (count_rise_tick) timer_count_value <= timer_count_value + 16'h0001;
        n_a <= n_a + capture_irq.irq_a;
        n_b <= n_b + capture_irq.irq_b;
        n_e <= n_e + count_edge_a;
        // Model: a capture holds the counter value seen at the last fall tick
        if (count_fall_tick) fall_val <= timer_count_value;
        last_a <= capture_reg_a;
        last_b <= capture_reg_b;
        if (resetn && capture_reg_a != last_a) chk("cap_a_val", capture_reg_a, fall_val);
        if (resetn && capture_reg_b != last_b) chk("cap_b_val", capture_reg_b, fall_val);
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic int edges(input logic [1:0] code);
        return (code == tce_pkg::EDGE_BOTH) ? 2 : (code == tce_pkg::EDGE_BAD) ? 0 : 1;
    endfunction : edges
    task automatic burst(input string nm, input logic [1:0] sel, input int w, input int ea, eb, ee);
        int a0 = n_a;
        int b0 = n_b;
        int e0 = n_e;
        src_u.pulse(sel, w);
        repeat (30) @(posedge clk_sys);
        chk({nm, " irq_a"}, n_a - a0, ea);
        chk({nm, " irq_b"}, n_b - b0, eb);
        chk({nm, " edge_a"}, n_e - e0, ee);
        $display("test %s done", nm);
    endtask : burst
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        void'($urandom(32'h13e3));
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        capture_compare_ctrl <= 3'h5;
        prescaler_mode_reg <= 4'h5;
        src_u.set_lvl(2'h1);
        repeat (8) @(posedge clk_sys);
        timer_run <= 1'b1;
        t0 = timer_count_value;
        burst("first_enable", 2'h0, 1, 1, 0, 0);
        chk("first_cap", (capture_reg_a - t0) inside {[16'h0000:16'h0008]}, 16'h0001);
        src_u.set_lvl(2'h0);
        // Let the falling pin settle before a code that treats it as valid
        repeat (20) @(posedge clk_sys);
        for (int c = 0; c < 4; c++) begin
            prescaler_mode_reg <= {c[1:0], c[1:0]};
            burst("edge_code", 2'h3, 12 + $urandom_range(15), edges(c[1:0]), edges(c[1:0]), 0);
        end
        burst("noise", 2'h3, 2, 0, 0, 0);
        timer_run <= 1'b0;
        burst("stopped", 2'h3, 14, 0, 0, 0);
        src_u.set_lvl(2'h3);
        prescaler_mode_reg <= 4'h5;
        repeat (10) @(posedge clk_sys);
        timer_run <= 1'b1;
        burst("reenable_high", 2'h0, 1, 0, 0, 0);
        src_u.set_lvl(2'h0);
        repeat (20) @(posedge clk_sys);
        clk_en <= 1'b0;
        burst("frozen", 2'h3, 14, 0, 0, 0);
        clk_en <= 1'b1;
        capture_compare_ctrl <= 3'h7;
        t0 = capture_reg_a;
        burst("rev_pin_a", 2'h1, 14, 0, 0, 0);
        chk("rev_cap_a", capture_reg_a != t0, 16'h0001);
        t0 = capture_reg_b;
        burst("rev_pin_b", 2'h2, 14, 1, 0, 0);
        chk("rev_cap_b", capture_reg_b, t0);
        capture_compare_ctrl <= 3'h5;
        trig_a_is_count_clk <= 1'b1;
        burst("pin_a_clock", 2'h1, 14, 0, 0, 1);
        end_of_test();
    end
endmodule : tce_capture_test

// file: verification/tce_src.sv
/* Trigger source model driving both capture pins.
   Assumes the bench calls its tasks from one process only. */
`timescale 1ns/10ps
module tce_src (
    input  wire logic clk_sys,
    output logic      trigger_in_a,
    output logic      trigger_in_b
);
    initial {trigger_in_b, trigger_in_a} = 2'h0;
    // Short widths are noise on purpose; real triggers outlast two count clocks
    task automatic pulse(input logic [1:0] sel, input int w);
        @(posedge clk_sys);
        {trigger_in_b, trigger_in_a} <= {trigger_in_b, trigger_in_a} | sel;
        repeat (w) @(posedge clk_sys);
        {trigger_in_b, trigger_in_a} <= {trigger_in_b, trigger_in_a} & ~sel;
    endtask : pulse
    task automatic set_lvl(input logic [1:0] v);
        @(posedge clk_sys);
        {trigger_in_b, trigger_in_a} <= v;
    endtask : set_lvl
endmodule : tce_src
